// ===== hw/cfjt_map.svh
// offsets, field positions, reset values and timing counts for the config/jtag pin block
`ifndef CFJT_MAP_SVH
`define CFJT_MAP_SVH
`define CFJT_CTRL_OFS        8'h00
`define CFJT_STAT_OFS        8'h04
`define CFJT_IRQ_STAT_OFS    8'h08
`define CFJT_IRQ_EN_OFS      8'h0C
`define CFJT_IRQ_CLR_OFS     8'h10
`define CFJT_DATA_OFS        8'h14
`define CFJT_CTRL_DONE_BIT   0
`define CFJT_CTRL_ERR_BIT    1
`define CFJT_CTRL_MIMG_BIT   2
`define CFJT_CTRL_RST        32'h0000_0000
`define CFJT_IRQ_DONE_BIT    0
`define CFJT_IRQ_RECFG_BIT   1
`define CFJT_IRQ_ERR_BIT     2
`define CFJT_IRQ_W           3
`define CFJT_IR_LEN          4
`define CFJT_IR_BYPASS       4'hF
`define CFJT_IR_IDCODE       4'h1
`define CFJT_IR_CFG          4'h2
`define CFJT_IDCODE_VAL      32'h1234_5001
`define CFJT_CLK_MHZ         125
`define CFJT_RECFG_MIN_NS    320
`define CFJT_RECFG_MIN_CYC   ((`CFJT_RECFG_MIN_NS * `CFJT_CLK_MHZ + 999) / 1000)
`define CFJT_CCLK_DIV        4
`endif

// ===== hw/cfjt_pkg.sv
// types for the config/jtag pin block
package cfjt_pkg;
  typedef enum logic [3:0] {
    TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR,
    TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR,
    TAP_SHIFT_IR, TAP_EXIT1_IR, TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
  } cfjt_tap_t;
  typedef enum logic [1:0] {
    CFG_IDLE, CFG_LOAD, CFG_WAIT_DONE, CFG_USER
  } cfjt_cfg_t;
endpackage

// ===== hw/cfjt_top.sv
// configuration and boundary-scan pin interface with ahb-lite register access
//
// Decided for this implementation: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "cfjt_map.svh"

// Overview of operation
// - done pin open-drain, released after configuration
// - hold off user mode while done low
// - restart on rising edge after long low
// - restart request also ends user mode
// - sample tms and tdi on tck rise
// - change tdo only after tck fall
// - floating tms or tdi read as one
// - shift tdi into ir or data register
// - tdo delay equals scan register length
// - tdo high-impedance when not shifting
// - three-bit width select, all high means x1
// - image select chooses image when enabled
// - passive takes clock, active drives clock
// - data pin roles swap with mode
// - configuration only while chip select high
// - release dual-purpose pins in user mode
// - mode pin sampled at restart rising edge
// - error output low on config failure
module cfjt_top #(
  parameter int DATA_W = 32
) (
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              hsel,
  input  wire logic [7:0]        haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic      [31:0]       hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  output logic                   irq,
  input  wire logic              config_done_flag_in,
  output logic                   config_done_flag_oe,
  input  wire logic              recfg_n,
  input  wire logic [2:0]        bus_width_select,
  input  wire logic [1:0]        image_select,
  input  wire logic              chip_select,
  input  wire logic              mode_sense,
  input  wire logic              config_clock_pin_in,
  output logic                   config_clock_pin_out,
  output logic                   config_clock_pin_oe,
  input  wire logic [DATA_W-1:0] config_data_pin_in,
  output logic      [DATA_W-1:0] config_data_pin_out,
  output logic      [DATA_W-1:0] config_data_pin_oe,
  output logic                   config_error_n,
  output logic                   user_mode,
  output logic [2:0]             cfg_width,
  output logic [1:0]             cfg_image,
  input  wire logic              tck,
  input  wire logic              tms,
  input  wire logic              tdi,
  output logic                   tdo,
  output logic                   tdo_oe
);
  if (DATA_W < 2 || DATA_W > 32) begin : g_bad_width
    $error("DATA_W must be 2..32");
  end

  // two-flop synchronisers for every outside pin
  // strap pins share the same chain, so width and image settle with mode
  localparam int SW = 14;
  logic [SW-1:0] s1_ff, s2_ff;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_ff <= '1;
      s2_ff <= '1;
    end else begin
      s1_ff <= {config_done_flag_in, recfg_n, chip_select, mode_sense,
                config_clock_pin_in, tck, tms, tdi, config_data_pin_in[0],
                bus_width_select, image_select};
      s2_ff <= s1_ff;
    end
  end
  logic done_s, rst_s, cs_s, mode_s, cclk_s, tck_s, tms_s, tdi_s, d0_s;
  logic [2:0] wsel_s;
  logic [1:0] isel_s;
  assign {done_s, rst_s, cs_s, mode_s, cclk_s, tck_s, tms_s, tdi_s, d0_s,
          wsel_s, isel_s} = s2_ff;
  logic [DATA_W-1:0] d1_ff, din_s;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      d1_ff <= '1;
      din_s <= '1;
    end else begin
      d1_ff <= config_data_pin_in;
      din_s <= d1_ff;
    end
  end

  // edge detection on synchronised levels
  logic rst_d_ff, tck_d_ff, cclk_d_ff;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rst_d_ff  <= 1'b1;
      tck_d_ff  <= 1'b1;
      cclk_d_ff <= 1'b1;
    end else begin
      rst_d_ff  <= rst_s;
      tck_d_ff  <= tck_s;
      cclk_d_ff <= cclk_s;
    end
  end
  wire tck_rise  = tck_s & ~tck_d_ff;
  wire tck_fall  = ~tck_s & tck_d_ff;
  wire rst_rise  = rst_s & ~rst_d_ff;
  wire cclk_rise = cclk_s & ~cclk_d_ff;

  // restart request low-time counter
  logic [15:0] low_cnt_ff;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) low_cnt_ff <= 16'h0000;
    else if (rst_s) low_cnt_ff <= 16'h0000;
    else if (low_cnt_ff != 16'hFFFF) low_cnt_ff <= low_cnt_ff + 16'h0001;
  end
  wire recfg_go = rst_rise && (low_cnt_ff >= 16'(`CFJT_RECFG_MIN_CYC));

  // ahb-lite slave
  logic        wr_pend_ff;
  logic [7:0]  wa_ff;
  logic [31:0] ctrl_ff;
  logic [`CFJT_IRQ_W-1:0] ists_ff, ien_ff;
  wire addr_ph = hsel & hready & htrans[1];
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff <= 1'b0;
      wa_ff      <= 8'h00;
    end else begin
      wr_pend_ff <= addr_ph & hwrite;
      if (addr_ph) wa_ff <= haddr;
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) ctrl_ff <= `CFJT_CTRL_RST;
    else if (wr_pend_ff && wa_ff == `CFJT_CTRL_OFS) ctrl_ff <= hwdata;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) ien_ff <= '0;
    else if (wr_pend_ff && wa_ff == `CFJT_IRQ_EN_OFS) ien_ff <= hwdata[`CFJT_IRQ_W-1:0];
  end
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // configuration controller
  cfjt_pkg::cfjt_cfg_t st_ff;
  logic       active_ff;
  logic [2:0] width_ff;
  logic [1:0] image_ff;
  logic [31:0] word_ff, data_cnt_ff;
  logic       err_ff;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_ff       <= cfjt_pkg::CFG_IDLE;
      active_ff   <= 1'b0;
      width_ff    <= 3'h7;
      image_ff    <= 2'h0;
      data_cnt_ff <= 32'h0000_0000;
      word_ff     <= 32'h0000_0000;
    end else if (recfg_go) begin
      st_ff       <= cfjt_pkg::CFG_LOAD;
      active_ff   <= mode_s;
      width_ff    <= wsel_s;
      image_ff    <= ctrl_ff[`CFJT_CTRL_MIMG_BIT] ? isel_s : 2'h0;
      data_cnt_ff <= 32'h0000_0000;
    end else begin
      unique case (st_ff)
        cfjt_pkg::CFG_IDLE: st_ff <= cfjt_pkg::CFG_IDLE;
        cfjt_pkg::CFG_LOAD: begin
          if (cs_s && cclk_rise) begin
            word_ff     <= (width_ff == 3'h7) ? {word_ff[30:0], active_ff ? din_s[1] : d0_s}
                                              : 32'(din_s);
            data_cnt_ff <= data_cnt_ff + 32'h0000_0001;
          end
          if (ctrl_ff[`CFJT_CTRL_DONE_BIT]) st_ff <= cfjt_pkg::CFG_WAIT_DONE;
        end
        cfjt_pkg::CFG_WAIT_DONE: if (done_s) st_ff <= cfjt_pkg::CFG_USER;
        cfjt_pkg::CFG_USER: st_ff <= cfjt_pkg::CFG_USER;
      endcase
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) err_ff <= 1'b0;
    else if (recfg_go) err_ff <= 1'b0;
    else if (ctrl_ff[`CFJT_CTRL_ERR_BIT] && st_ff == cfjt_pkg::CFG_LOAD) err_ff <= 1'b1;
  end
  wire loading = (st_ff == cfjt_pkg::CFG_LOAD);

  // active-mode clock divider
  logic [3:0] div_ff;
  logic       cclk_ff;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_ff  <= 4'h0;
      cclk_ff <= 1'b1;
    end else if (div_ff == 4'(`CFJT_CCLK_DIV - 1)) begin
      div_ff  <= 4'h0;
      cclk_ff <= ~cclk_ff;
    end else div_ff <= div_ff + 4'h1;
  end

  // pin drivers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      config_done_flag_oe  <= 1'b1;
      config_clock_pin_out <= 1'b1;
      config_clock_pin_oe  <= 1'b0;
      config_data_pin_out  <= '0;
      config_data_pin_oe   <= '0;
      config_error_n       <= 1'b1;
      user_mode            <= 1'b0;
      cfg_width            <= 3'h7;
      cfg_image            <= 2'h0;
    end else begin
      config_done_flag_oe  <= (st_ff == cfjt_pkg::CFG_IDLE) || loading;
      config_clock_pin_out <= cclk_ff;
      config_clock_pin_oe  <= loading & active_ff;
      config_data_pin_out  <= {{(DATA_W-1){1'b0}}, word_ff[31]};
      // active drives pin 0, passive drives pin 1
      config_data_pin_oe   <= !loading ? '0 :
                              active_ff ? DATA_W'(1) : DATA_W'(2);
      config_error_n       <= ~err_ff;
      user_mode            <= (st_ff == cfjt_pkg::CFG_USER);
      cfg_width            <= width_ff;
      cfg_image            <= image_ff;
    end
  end

  // tap controller on sampled tck edges; undriven pins arrive pulled high
  cfjt_pkg::cfjt_tap_t tap_ff;
  logic [`CFJT_IR_LEN-1:0] ir_ff, ir_sh_ff;
  logic [31:0] dr_sh_ff, cfg_dr_ff;
  logic        byp_ff;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) tap_ff <= cfjt_pkg::TAP_RESET;
    else if (tck_rise) begin
      unique case (tap_ff)
        cfjt_pkg::TAP_RESET:    tap_ff <= tms_s ? cfjt_pkg::TAP_RESET  : cfjt_pkg::TAP_IDLE;
        cfjt_pkg::TAP_IDLE:     tap_ff <= tms_s ? cfjt_pkg::TAP_SEL_DR : cfjt_pkg::TAP_IDLE;
        cfjt_pkg::TAP_SEL_DR:   tap_ff <= tms_s ? cfjt_pkg::TAP_SEL_IR : cfjt_pkg::TAP_CAP_DR;
        cfjt_pkg::TAP_CAP_DR:   tap_ff <= tms_s ? cfjt_pkg::TAP_EXIT1_DR : cfjt_pkg::TAP_SHIFT_DR;
        cfjt_pkg::TAP_SHIFT_DR: tap_ff <= tms_s ? cfjt_pkg::TAP_EXIT1_DR : cfjt_pkg::TAP_SHIFT_DR;
        cfjt_pkg::TAP_EXIT1_DR: tap_ff <= tms_s ? cfjt_pkg::TAP_UPD_DR : cfjt_pkg::TAP_PAUSE_DR;
        cfjt_pkg::TAP_PAUSE_DR: tap_ff <= tms_s ? cfjt_pkg::TAP_EXIT2_DR : cfjt_pkg::TAP_PAUSE_DR;
        cfjt_pkg::TAP_EXIT2_DR: tap_ff <= tms_s ? cfjt_pkg::TAP_UPD_DR : cfjt_pkg::TAP_SHIFT_DR;
        cfjt_pkg::TAP_UPD_DR:   tap_ff <= tms_s ? cfjt_pkg::TAP_SEL_DR : cfjt_pkg::TAP_IDLE;
        cfjt_pkg::TAP_SEL_IR:   tap_ff <= tms_s ? cfjt_pkg::TAP_RESET  : cfjt_pkg::TAP_CAP_IR;
        cfjt_pkg::TAP_CAP_IR:   tap_ff <= tms_s ? cfjt_pkg::TAP_EXIT1_IR : cfjt_pkg::TAP_SHIFT_IR;
        cfjt_pkg::TAP_SHIFT_IR: tap_ff <= tms_s ? cfjt_pkg::TAP_EXIT1_IR : cfjt_pkg::TAP_SHIFT_IR;
        cfjt_pkg::TAP_EXIT1_IR: tap_ff <= tms_s ? cfjt_pkg::TAP_UPD_IR : cfjt_pkg::TAP_PAUSE_IR;
        cfjt_pkg::TAP_PAUSE_IR: tap_ff <= tms_s ? cfjt_pkg::TAP_EXIT2_IR : cfjt_pkg::TAP_PAUSE_IR;
        cfjt_pkg::TAP_EXIT2_IR: tap_ff <= tms_s ? cfjt_pkg::TAP_UPD_IR : cfjt_pkg::TAP_SHIFT_IR;
        cfjt_pkg::TAP_UPD_IR:   tap_ff <= tms_s ? cfjt_pkg::TAP_SEL_DR : cfjt_pkg::TAP_IDLE;
      endcase
    end
  end
  // scan registers: ir, idcode/config word, bypass
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ir_ff     <= `CFJT_IR_IDCODE;
      ir_sh_ff  <= '0;
      dr_sh_ff  <= 32'h0000_0000;
      cfg_dr_ff <= 32'h0000_0000;
      byp_ff    <= 1'b0;
    end else if (tck_rise) begin
      unique case (tap_ff)
        cfjt_pkg::TAP_RESET:    ir_ff <= `CFJT_IR_IDCODE;
        cfjt_pkg::TAP_CAP_IR:   ir_sh_ff <= `CFJT_IR_LEN'(1);
        cfjt_pkg::TAP_SHIFT_IR: ir_sh_ff <= {tdi_s, ir_sh_ff[`CFJT_IR_LEN-1:1]};
        cfjt_pkg::TAP_UPD_IR:   ir_ff <= ir_sh_ff;
        cfjt_pkg::TAP_CAP_DR: begin
          byp_ff   <= 1'b0;
          dr_sh_ff <= (ir_ff == `CFJT_IR_IDCODE) ? `CFJT_IDCODE_VAL : cfg_dr_ff;
        end
        cfjt_pkg::TAP_SHIFT_DR: begin
          byp_ff   <= tdi_s;
          dr_sh_ff <= {tdi_s, dr_sh_ff[31:1]};
        end
        cfjt_pkg::TAP_UPD_DR: if (ir_ff == `CFJT_IR_CFG && cs_s) cfg_dr_ff <= dr_sh_ff;
        default: ;
      endcase
    end
  end
  // tdo changes on the falling edge only
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tdo    <= 1'b0;
      tdo_oe <= 1'b0;
    end else if (tck_fall) begin
      tdo_oe <= (tap_ff == cfjt_pkg::TAP_SHIFT_DR) || (tap_ff == cfjt_pkg::TAP_SHIFT_IR);
      if (tap_ff == cfjt_pkg::TAP_SHIFT_IR) tdo <= ir_sh_ff[0];
      else if (ir_ff == `CFJT_IR_BYPASS) tdo <= byp_ff;
      else tdo <= dr_sh_ff[0];
    end
  end

  // interrupts: sticky status, set wins over clear
  wire [`CFJT_IRQ_W-1:0] ev = {(st_ff == cfjt_pkg::CFG_LOAD) & ctrl_ff[`CFJT_CTRL_ERR_BIT] & ~err_ff,
                               recfg_go,
                               (st_ff == cfjt_pkg::CFG_WAIT_DONE) & done_s};
  wire [`CFJT_IRQ_W-1:0] clr = (wr_pend_ff && wa_ff == `CFJT_IRQ_CLR_OFS) ?
                               hwdata[`CFJT_IRQ_W-1:0] : '0;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) ists_ff <= '0;
    else ists_ff <= (ists_ff & ~clr) | ev;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) irq <= 1'b0;
    else irq <= |(((ists_ff & ~clr) | ev) & ien_ff);
  end

  // read data
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) hrdata <= 32'h0000_0000;
    else if (addr_ph && !hwrite) begin
      unique case (haddr)
        `CFJT_CTRL_OFS:     hrdata <= ctrl_ff;
        `CFJT_STAT_OFS:     hrdata <= {22'h0, err_ff, active_ff, image_ff, width_ff,
                                       done_s, 2'(st_ff)};
        `CFJT_IRQ_STAT_OFS: hrdata <= 32'(ists_ff);
        `CFJT_IRQ_EN_OFS:   hrdata <= 32'(ien_ff);
        `CFJT_DATA_OFS:     hrdata <= word_ff;
        default:            hrdata <= 32'h0000_0000;
      endcase
    end
  end
endmodule // cfjt_top

// ===== tb/cfjt_chk.sv
// port-level assertions for the config/jtag pin block
`timescale 1ns/1ps
module cfjt_chk #(
  parameter int DATA_W = 32
) (
  input wire logic              hclk,
  input wire logic              hresetn,
  input wire logic              recfg_n,
  input wire logic              config_done_flag_in,
  input wire logic              config_done_flag_oe,
  input wire logic              config_clock_pin_oe,
  input wire logic [DATA_W-1:0] config_data_pin_oe,
  input wire logic              config_error_n,
  input wire logic              user_mode,
  input wire logic              tck,
  input wire logic              tdo,
  input wire logic              tdo_oe
);
  int low_cnt_ff;
  int last_low_ff;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      low_cnt_ff <= 0;
    end else begin
      low_cnt_ff <= recfg_n ? 0 : low_cnt_ff + 1;
    end
  end
  // length of the latest restart pulse
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      last_low_ff <= 0;
    end else if (recfg_n && low_cnt_ff != 0) begin
      last_low_ff <= low_cnt_ff;
    end
  end
  a_restart_min: assert property ($rose(|config_data_pin_oe) |-> last_low_ff >= 40)
    else $error("load began after a short restart pulse");
  a_user_needs_done: assert property ($rose(user_mode) |-> $past(config_done_flag_in))
    else $error("user mode entered while done line low");
  a_done_released: assert property ($rose(user_mode) |-> !config_done_flag_oe)
    else $error("done pin still pulled low in user mode");
  a_pins_freed: assert property (user_mode |-> !config_clock_pin_oe && config_data_pin_oe == '0)
    else $error("config pins still driven in user mode");
  a_active_roles: assert property (config_clock_pin_oe && $past(config_clock_pin_oe)
    |-> config_data_pin_oe[0] && !config_data_pin_oe[1])
    else $error("active load drives the wrong data pin");
  a_passive_roles: assert property (config_data_pin_oe[1] && $past(config_data_pin_oe[1])
    |-> !config_clock_pin_oe)
    else $error("passive load drives the config clock");
  a_tdo_on_fall: assert property ($changed(tdo) || $changed(tdo_oe) |-> !tck)
    else $error("tdo changed while tck high");
  a_error_load: assert property ($fell(config_error_n) |-> !user_mode)
    else $error("error flagged outside a load");
  a_done_fall: assert property ($fell(config_done_flag_oe) |-> !user_mode ##1 !user_mode)
    else $error("done released with user mode already on");
  c_user: cover property ($rose(user_mode));
  c_active: cover property ($rose(config_clock_pin_oe));
  c_error: cover property ($fell(config_error_n));
  c_shift: cover property ($rose(tdo_oe));
endmodule // cfjt_chk

bind cfjt_top cfjt_chk #(.DATA_W(DATA_W)) u_chk (
  .hclk, .hresetn, .recfg_n, .config_done_flag_in, .config_done_flag_oe, .config_clock_pin_oe,
  .config_data_pin_oe, .config_error_n, .user_mode, .tck, .tdo, .tdo_oe
);

// ===== tb/cfjt_host_model.sv
// behavioural configuration host: restart pulses and passive serial load
`timescale 1ns/1ps
module cfjt_host_model (
  input  wire logic        hclk,
  output logic             recfg_n,
  output logic             host_clk,
  output logic [31:0]      host_data
);
  initial begin
    recfg_n = 1'b1;
    host_clk = 1'b1;
    host_data = 32'h0000_0000;
  end
  task automatic restart(input int low_cyc);
    recfg_n <= 1'b0;
    repeat (low_cyc) @(posedge hclk);
    recfg_n <= 1'b1;
    repeat (8) @(posedge hclk);
  endtask
  // msb first on pin 0, clock idles high between frames
  task automatic send_word(input logic [31:0] wd);
    for (int i = 31; i >= 0; i--) begin
      host_clk <= 1'b0;
      host_data[0] <= wd[i];
      repeat (5) @(posedge hclk);
      host_clk <= 1'b1;
      repeat (5) @(posedge hclk);
    end
    host_data <= ~host_data;
  endtask
endmodule // cfjt_host_model

// ===== tb/testbench.sv
// self-checking bench for the config/jtag pin block
`timescale 1ns/1ps
`include "cfjt_map.svh"
`define TB_CHK(g, e) begin \
  n_compared++; \
  if ((g) !== (e)) begin \
    err_count++; \
    $display("[FAIL] %0t got %0h exp %0h", $time, (g), (e)); \
  end \
end
module testbench;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic [7:0]  haddr = 8'h00;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [2:0]  bus_width_select = 3'h7;
  logic [1:0]  image_select = 2'h0;
  logic        chip_select = 1'b1;
  logic        mode_sense = 1'b0;
  logic        tck = 1'b0;
  logic        tms = 1'b1;
  logic        tdi = 1'b1;
  logic        hold_low = 1'b0;
  logic        hready, hreadyout, hresp, irq, recfg_n, host_clk, ts, tdo, tdo_oe;
  logic        config_done_flag_in, config_done_flag_oe, config_error_n, user_mode;
  logic        config_clock_pin_in, config_clock_pin_out, config_clock_pin_oe;
  logic [31:0] hrdata, config_data_pin_in, config_data_pin_out, config_data_pin_oe;
  logic [31:0] host_data, rd, w;
  logic [2:0]  cfg_width;
  logic [1:0]  cfg_image;
  logic        q[$];
  int          err_count = 0;
  int          n_compared = 0;

  always #4 hclk = ~hclk;
  assign hready = hreadyout;
  assign config_done_flag_in = !config_done_flag_oe && !hold_low;
  assign config_clock_pin_in = config_clock_pin_oe ? config_clock_pin_out : host_clk;
  assign config_data_pin_in = (config_data_pin_oe & config_data_pin_out)
                            | (~config_data_pin_oe & host_data);

  cfjt_top #(.DATA_W(32)) dut (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata,
    .hreadyout, .hresp, .irq, .config_done_flag_in, .config_done_flag_oe, .recfg_n,
    .bus_width_select, .image_select, .chip_select, .mode_sense, .config_clock_pin_in,
    .config_clock_pin_out, .config_clock_pin_oe, .config_data_pin_in, .config_data_pin_out,
    .config_data_pin_oe, .config_error_n, .user_mode, .cfg_width, .cfg_image, .tck, .tms,
    .tdi, .tdo, .tdo_oe
  );
  cfjt_host_model hm (.hclk, .recfg_n, .host_clk, .host_data);

  task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic jc(input logic m, input logic d);
    tms <= m;
    tdi <= d;
    repeat (2) @(posedge hclk);
    tck <= 1'b1;
    repeat (3) @(posedge hclk);
    tck <= 1'b0;
    repeat (5) @(posedge hclk);
    ts = tdo;
  endtask
  task automatic path(input logic [15:0] ms, input int n);
    for (int i = 0; i < n; i++) jc(ms[i], 1'b1);
  endtask
  // reference shift path: the queue holds what the scan register holds
  task automatic scan(input int n, input logic [31:0] pat);
    logic e;
    `TB_CHK(tdo_oe, 1'b1)
    e = q.pop_front();
    `TB_CHK(ts, e)
    for (int i = 0; i < n; i++) begin
      q.push_back(pat[i]);
      jc(1'b0, pat[i]);
      e = q.pop_front();
      `TB_CHK(ts, e)
    end
  endtask
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    #300000;
    err_count++;
    report_and_stop();
  end
  initial begin
    w = $urandom(32'hED3B3245);
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    `TB_CHK(config_done_flag_oe, 1'b1)
    `TB_CHK(tdo_oe, 1'b0)
    bus(8'h40, 1'b0, 32'h0);
    `TB_CHK(rd, 32'h0000_0000)
    bus(`CFJT_IRQ_EN_OFS, 1'b1, 32'h7);
    bus(`CFJT_CTRL_OFS, 1'b1, 32'h4);
    hm.restart(20);
    bus(`CFJT_IRQ_STAT_OFS, 1'b0, 32'h0);
    `TB_CHK(rd[1], 1'b0)
    image_select <= 2'($urandom);
    hm.restart(41);
    `TB_CHK(config_data_pin_oe, 32'h2)
    `TB_CHK(config_clock_pin_oe, 1'b0)
    `TB_CHK(cfg_width, 3'h7)
    `TB_CHK(cfg_image, image_select)
    `TB_CHK(irq, 1'b1)
    bus(`CFJT_IRQ_CLR_OFS, 1'b1, 32'h7);
    repeat (2) @(posedge hclk);
    `TB_CHK(irq, 1'b0)
    w = $urandom;
    hm.send_word(w);
    bus(`CFJT_DATA_OFS, 1'b0, 32'h0);
    `TB_CHK(rd, w)
    chip_select <= 1'b0;
    hm.send_word(~w);
    bus(`CFJT_DATA_OFS, 1'b0, 32'h0);
    `TB_CHK(rd, w)
    chip_select <= 1'b1;
    hold_low <= 1'b1;
    bus(`CFJT_CTRL_OFS, 1'b1, 32'h5);
    repeat (10) @(posedge hclk);
    `TB_CHK(config_done_flag_oe, 1'b0)
    `TB_CHK(user_mode, 1'b0)
    hold_low <= 1'b0;
    repeat (8) @(posedge hclk);
    `TB_CHK(user_mode, 1'b1)
    `TB_CHK(config_data_pin_oe, 32'h0)
    bus(`CFJT_IRQ_STAT_OFS, 1'b0, 32'h0);
    `TB_CHK(rd[0], 1'b1)
    // drop the load-complete bit so the next load stays in progress
    bus(`CFJT_CTRL_OFS, 1'b1, 32'h4);
    mode_sense <= 1'b1;
    bus_width_select <= 3'($urandom);
    hm.restart(41);
    `TB_CHK(config_clock_pin_oe, 1'b1)
    `TB_CHK(config_data_pin_oe, 32'h1)
    `TB_CHK(cfg_width, bus_width_select)
    w[0] = config_clock_pin_out;
    repeat (`CFJT_CCLK_DIV) @(posedge hclk);
    `TB_CHK(config_clock_pin_out, ~w[0])
    bus(`CFJT_IRQ_EN_OFS, 1'b0, 32'h0);
    `TB_CHK(rd[2:0], 3'h7)
    bus(`CFJT_CTRL_OFS, 1'b1, 32'h2);
    repeat (3) @(posedge hclk);
    `TB_CHK(config_error_n, 1'b0)
    w = `CFJT_IDCODE_VAL;
    for (int i = 0; i < 32; i++) q.push_back(w[i]);
    path(16'h005F, 9);
    scan(31, $urandom);
    path(16'h0003, 3);
    `TB_CHK(tdo_oe, 1'b0)
    q = {1'b1, 1'b0, 1'b0, 1'b0};
    path(16'h0003, 4);
    scan(3, 32'hF);
    jc(1'b1, 1'b1);
    q = {1'b0};
    path(16'h0005, 5);
    scan(8, $urandom);
    path(16'h0003, 3);
    report_and_stop();
  end
endmodule // testbench
